// ---- verilog/analog_test_aux_register_bank.sv ----
// Analog test and aux pin register bank with APB slave
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "aux_test_params.svh"

// Behaviour
// RULE1: Read-only 8-bit version register at 37h, value fixed by silicon.
// RULE2: Selector 0000 floats the pin, 1010 drives high, 1011 drives low.
// RULE3: Code 0001 routes first DAC to first pin, second to second.
// RULE4: Codes 0100-0110 give min level, I, Q; 0010 gives correlator.
// RULE5: Codes 0011, 0111, 1000, 1001 reserved; 1000 is production test.
// RULE6: Code 1100 outputs the transmit active flag.
// RULE7: Code 1101 outputs the receive active flag.
// RULE8: Code 1110 outputs subcarrier detected, meaningless at 106 kBd.
// RULE9: A code drives one test bus bit chosen by a 3-bit field.
// RULE10: Selectors at 38h bits 7:4 and 3:0, reset 00h.
// RULE11: 6-bit first DAC value at 39h bits 5:0.
// RULE12: 6-bit second DAC value at 3Ah, bits 7:6 reserved.
// RULE13: Read-only 3Bh returns I sample high, Q sample low.
// RULE14: 3Ch reserved for production test, no functional use.
// RULE15: Test bus bit selection uses selector code 1111.
module analog_test_aux_register_bank #(
    // Arbitrary neutral value
    parameter logic [7:0] VERSION_CODE = 8'h5A
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    // APB slave
    input  wire logic [7:0]            paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Test sources
    input  wire logic                  correlator_signal,
    input  wire aux_test_pkg::nibble_t receiver_minimum_level,
    input  wire aux_test_pkg::nibble_t adc_i_sample,
    input  wire aux_test_pkg::nibble_t adc_q_sample,
    input  wire logic                  production_test_signal,
    input  wire logic                  transmit_active_flag,
    input  wire logic                  receive_active_flag,
    input  wire logic                  subcarrier_flag,
    input  wire logic                  baud_is_106,
    input  wire logic [7:0]            test_bus,
    // First aux pin
    output logic                       first_auxiliary_pin_out,
    output logic                       first_auxiliary_pin_oe,
    output aux_test_pkg::dac_val_t     first_auxiliary_pin_level,
    output logic                       first_auxiliary_pin_level_en,
    // Second aux pin
    output logic                       second_auxiliary_pin_out,
    output logic                       second_auxiliary_pin_oe,
    output aux_test_pkg::dac_val_t     second_auxiliary_pin_level,
    output logic                       second_auxiliary_pin_level_en
);
    import aux_test_pkg::*;

    localparam logic [7:0] SEL_RESET = `AUX_SEL_RST;

    aux_sel_t   first_pin_selector;
    aux_sel_t   second_pin_selector;
    dac_val_t   first_test_dac_value;
    dac_val_t   second_test_dac_value;
    logic [2:0] test_bus_bit_select;
    logic       setup_phase;
    logic       access_phase;
    logic       wr_en;
    logic [7:0] read_value;
    logic       mapped;

    aux_pin_if first_pin ();
    aux_pin_if second_pin ();

    // Byte address hit for a register index
    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [7:0] idx);
        reg_hit = (addr == {idx[5:0], 2'b00});
    endfunction

    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign wr_en        = access_phase & pwrite;
    assign pready       = 1'b1;

    // Address decode and read mux
    always_comb begin
        read_value = 8'h00;
        mapped     = 1'b1;
        // RULE1: version readback
        if (reg_hit(paddr, `SILICON_VERSION_IDX)) begin
            read_value = VERSION_CODE;
        end else if (reg_hit(paddr, `AUX_SEL_IDX)) begin
            read_value = {first_pin_selector, second_pin_selector};
        end else if (reg_hit(paddr, `FIRST_DAC_IDX)) begin
            read_value = {2'b00, first_test_dac_value};
        end else if (reg_hit(paddr, `SECOND_DAC_IDX)) begin
            // RULE12: reserved bits read zero
            read_value = {2'b00, second_test_dac_value};
        end else if (reg_hit(paddr, `ADC_IQ_IDX)) begin
            // RULE13: I and Q samples
            read_value = {adc_i_sample, adc_q_sample};
        end else if (reg_hit(paddr, `PROD_TEST_IDX)) begin
            // RULE14: fixed reserved value
            read_value = `PROD_TEST_READ;
        end else if (reg_hit(paddr, `TEST_SEL_IDX)) begin
            read_value = {5'b00000, test_bus_bit_select};
        end else begin
            mapped = 1'b0;
        end
    end

    assign pslverr = access_phase & ~mapped;

    // Read data captured in setup cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase) begin
            prdata <= {24'h00_0000, read_value};
        end
    end

    // RULE10: selector register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            first_pin_selector  <=
                aux_sel_t'(SEL_RESET[`FIRST_SEL_MSB:`FIRST_SEL_LSB]);
            second_pin_selector <=
                aux_sel_t'(SEL_RESET[`SECOND_SEL_MSB:`SECOND_SEL_LSB]);
        end else if (wr_en && reg_hit(paddr, `AUX_SEL_IDX)) begin
            first_pin_selector  <=
                aux_sel_t'(pwdata[`FIRST_SEL_MSB:`FIRST_SEL_LSB]);
            second_pin_selector <=
                aux_sel_t'(pwdata[`SECOND_SEL_MSB:`SECOND_SEL_LSB]);
        end
    end

    // RULE11: first DAC value
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            first_test_dac_value <= `DAC_RST;
        end else if (wr_en && reg_hit(paddr, `FIRST_DAC_IDX)) begin
            first_test_dac_value <= pwdata[`DAC_MSB:0];
        end
    end

    // RULE12: second DAC value
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            second_test_dac_value <= `DAC_RST;
        end else if (wr_en && reg_hit(paddr, `SECOND_DAC_IDX)) begin
            second_test_dac_value <= pwdata[`DAC_MSB:0];
        end
    end

    // RULE9: test bus bit select field
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            test_bus_bit_select <= `BIT_SEL_RST;
        end else if (wr_en && reg_hit(paddr, `TEST_SEL_IDX)) begin
            test_bus_bit_select <= pwdata[`BIT_SEL_MSB:0];
        end
    end

    // Selector drive
    assign first_pin.sel  = first_pin_selector;
    assign first_pin.dac  = first_test_dac_value;
    assign second_pin.sel = second_pin_selector;
    assign second_pin.dac = second_test_dac_value;

    aux_pin_mux u_first_mux (
        .pin                    (first_pin.mux),
        .correlator_signal      (correlator_signal),
        .receiver_minimum_level (receiver_minimum_level),
        .adc_i_sample           (adc_i_sample),
        .adc_q_sample           (adc_q_sample),
        .production_test_signal (production_test_signal),
        .transmit_active_flag   (transmit_active_flag),
        .receive_active_flag    (receive_active_flag),
        .subcarrier_flag        (subcarrier_flag),
        .baud_is_106            (baud_is_106),
        .test_bus               (test_bus),
        .test_bus_bit_select    (test_bus_bit_select)
    );

    aux_pin_mux u_second_mux (
        .pin                    (second_pin.mux),
        .correlator_signal      (correlator_signal),
        .receiver_minimum_level (receiver_minimum_level),
        .adc_i_sample           (adc_i_sample),
        .adc_q_sample           (adc_q_sample),
        .production_test_signal (production_test_signal),
        .transmit_active_flag   (transmit_active_flag),
        .receive_active_flag    (receive_active_flag),
        .subcarrier_flag        (subcarrier_flag),
        .baud_is_106            (baud_is_106),
        .test_bus               (test_bus),
        .test_bus_bit_select    (test_bus_bit_select)
    );

    // Registered first pin
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            first_auxiliary_pin_out      <= 1'b0;
            first_auxiliary_pin_oe       <= 1'b0;
            first_auxiliary_pin_level    <= '0;
            first_auxiliary_pin_level_en <= 1'b0;
        end else begin
            first_auxiliary_pin_out      <= first_pin.pin_out;
            first_auxiliary_pin_oe       <= first_pin.pin_oe;
            first_auxiliary_pin_level    <= first_pin.level;
            first_auxiliary_pin_level_en <= first_pin.level_en;
        end
    end

    // Registered second pin
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            second_auxiliary_pin_out      <= 1'b0;
            second_auxiliary_pin_oe       <= 1'b0;
            second_auxiliary_pin_level    <= '0;
            second_auxiliary_pin_level_en <= 1'b0;
        end else begin
            second_auxiliary_pin_out      <= second_pin.pin_out;
            second_auxiliary_pin_oe       <= second_pin.pin_oe;
            second_auxiliary_pin_level    <= second_pin.level;
            second_auxiliary_pin_level_en <= second_pin.level_en;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    sequence rd_access(logic [7:0] idx);
        setup_phase && !pwrite && reg_hit(paddr, idx) ##1 access_phase;
    endsequence

    version_read_a: assert property ( // RULE1
        rd_access(`SILICON_VERSION_IDX) |-> prdata[7:0] == VERSION_CODE
    ) else $error("version read wrong");

    hiz_code_a: assert property ( // RULE2
        $past(first_pin_selector) == SEL_HIZ |-> !first_auxiliary_pin_oe
    ) else $error("pin not floating for code 0000");

    fixed_level_a: assert property ( // RULE2
        $past(second_pin_selector) == SEL_HIGH |->
            second_auxiliary_pin_oe && second_auxiliary_pin_out
    ) else $error("pin not high for code 1010");

    dac_route_a: assert property ( // RULE3
        $past(second_pin_selector) == SEL_DAC |->
            second_auxiliary_pin_level_en &&
            second_auxiliary_pin_level == $past(second_test_dac_value)
    ) else $error("second DAC not routed");

    adc_route_a: assert property ( // RULE4
        $past(first_pin_selector) == SEL_ADC_I |->
            first_auxiliary_pin_level == {$past(adc_i_sample), 2'b00}
    ) else $error("I sample not routed");

    reserved_hiz_a: assert property ( // RULE5
        $past(first_pin_selector) == SEL_RSV9 |->
            !first_auxiliary_pin_oe && !first_auxiliary_pin_level_en
    ) else $error("reserved code drives pin");

    tx_route_a: assert property ( // RULE6
        $past(first_pin_selector) == SEL_TX |->
            first_auxiliary_pin_out == $past(transmit_active_flag)
    ) else $error("transmit flag not routed");

    rx_route_a: assert property ( // RULE7
        $past(second_pin_selector) == SEL_RX |->
            second_auxiliary_pin_out == $past(receive_active_flag)
    ) else $error("receive flag not routed");

    subc_106_a: assert property ( // RULE8
        $past(first_pin_selector) == SEL_SUBC && $past(baud_is_106) |->
            !first_auxiliary_pin_out
    ) else $error("subcarrier high at 106 kBd");

    bus_bit_a: assert property ( // RULE15
        $past(first_pin_selector) == SEL_BUS_BIT |->
            first_auxiliary_pin_out ==
            $past(test_bus[test_bus_bit_select])
    ) else $error("test bus bit not routed");

    sel_write_a: assert property ( // RULE10
        wr_en && reg_hit(paddr, `AUX_SEL_IDX) |=>
            {first_pin_selector, second_pin_selector} ==
            $past(pwdata[7:0])
    ) else $error("selector write lost");

    dac_write_a: assert property ( // RULE11
        wr_en && reg_hit(paddr, `FIRST_DAC_IDX) |=>
            first_test_dac_value == $past(pwdata[5:0])
    ) else $error("first DAC write lost");

    adc_read_a: assert property ( // RULE13
        setup_phase && !pwrite && reg_hit(paddr, `ADC_IQ_IDX) |=>
            prdata[7:0] == {$past(adc_i_sample), $past(adc_q_sample)}
    ) else $error("ADC sample read wrong");

    rsvd_read_a: assert property ( // RULE14
        rd_access(`PROD_TEST_IDX) |-> prdata[7:0] == `PROD_TEST_READ
    ) else $error("reserved register read wrong");

    low_level_a: assert property ( // RULE2
        $past(first_pin_selector) == SEL_LOW |->
            first_auxiliary_pin_oe && !first_auxiliary_pin_out
    ) else $error("pin not low for code 1011");

    first_dac_route_a: assert property ( // RULE3
        $past(first_pin_selector) == SEL_DAC |->
            first_auxiliary_pin_level_en &&
            first_auxiliary_pin_level == $past(first_test_dac_value)
    ) else $error("first DAC not routed");

    dac2_write_a: assert property ( // RULE12
        wr_en && reg_hit(paddr, `SECOND_DAC_IDX) |=>
            second_test_dac_value == $past(pwdata[5:0])
    ) else $error("second DAC write lost");

    bit_sel_write_a: assert property ( // RULE9
        wr_en && reg_hit(paddr, `TEST_SEL_IDX) |=>
            test_bus_bit_select == $past(pwdata[2:0])
    ) else $error("bit select write lost");

    sel_hold_a: assert property ( // RULE10
        !(wr_en && reg_hit(paddr, `AUX_SEL_IDX)) |=>
            $stable(first_pin_selector) && $stable(second_pin_selector)
    ) else $error("selector changed without write");

    dac_route_c: cover property (
        $past(first_pin_selector) == SEL_DAC && first_auxiliary_pin_level_en
    );
    bus_bit_c: cover property (
        $past(second_pin_selector) == SEL_BUS_BIT && second_auxiliary_pin_out
    );
    unmapped_c: cover property (pslverr);
    write_then_read_c: cover property (
        wr_en && reg_hit(paddr, `AUX_SEL_IDX) ##[1:8]
            rd_access(`AUX_SEL_IDX)
    );
    subc_106_c: cover property (
        $past(first_pin_selector) == SEL_SUBC && $past(baud_is_106)
    );
endmodule

// ---- inc/aux_test_params.svh ----
// Offsets, field positions, reset values and timing of the aux test bank
`ifndef AUX_TEST_PARAMS_SVH
`define AUX_TEST_PARAMS_SVH

// Register indices; byte address is four times the index
`define SILICON_VERSION_IDX 8'h37
`define AUX_SEL_IDX         8'h38
`define FIRST_DAC_IDX       8'h39
`define SECOND_DAC_IDX      8'h3A
`define ADC_IQ_IDX          8'h3B
`define PROD_TEST_IDX       8'h3C
`define TEST_SEL_IDX        8'h30

// Field positions
`define FIRST_SEL_MSB  7
`define FIRST_SEL_LSB  4
`define SECOND_SEL_MSB 3
`define SECOND_SEL_LSB 0
`define DAC_MSB        5
`define BIT_SEL_MSB    2
`define ADC_I_MSB      7
`define ADC_I_LSB      4
`define ADC_Q_MSB      3
`define ADC_Q_LSB      0

// Reset and fixed read values
`define AUX_SEL_RST    8'h00
`define DAC_RST        6'h00
`define BIT_SEL_RST    3'h0
`define PROD_TEST_READ 8'hFF

// Timing: registered pin path latency in clk_sys cycles
`define PIN_LATENCY    1

`endif

// ---- inc/aux_test_pkg.sv ----
// Types shared by the aux test register bank
package aux_test_pkg;

    typedef enum logic [3:0] {
        SEL_HIZ     = 4'b0000,
        SEL_DAC     = 4'b0001,
        SEL_CORR    = 4'b0010,
        SEL_RSV3    = 4'b0011,
        SEL_MINLVL  = 4'b0100,
        SEL_ADC_I   = 4'b0101,
        SEL_ADC_Q   = 4'b0110,
        SEL_RSV7    = 4'b0111,
        SEL_PROD    = 4'b1000,
        SEL_RSV9    = 4'b1001,
        SEL_HIGH    = 4'b1010,
        SEL_LOW     = 4'b1011,
        SEL_TX      = 4'b1100,
        SEL_RX      = 4'b1101,
        SEL_SUBC    = 4'b1110,
        SEL_BUS_BIT = 4'b1111
    } aux_sel_t;

    typedef logic [5:0] dac_val_t;
    typedef logic [3:0] nibble_t;

endpackage

// ---- inc/aux_pin_if.sv ----
// Carrier between the register bank and one aux pin selector
`timescale 1ns/1ps
interface aux_pin_if;
    import aux_test_pkg::*;
    aux_sel_t sel;
    dac_val_t dac;
    logic     pin_out;
    logic     pin_oe;
    dac_val_t level;
    logic     level_en;

    modport ctrl (
        output sel,
        output dac,
        input  pin_out,
        input  pin_oe,
        input  level,
        input  level_en
    );
    modport mux (
        input  sel,
        input  dac,
        output pin_out,
        output pin_oe,
        output level,
        output level_en
    );
endinterface

// ---- verilog/aux_pin_mux.sv ----
// Selector that routes one test source onto an aux pin
`timescale 1ns/1ps
module aux_pin_mux (
    // Selector side
    aux_pin_if.mux                 pin,
    // Test sources
    input  wire logic              correlator_signal,
    input  wire aux_test_pkg::nibble_t receiver_minimum_level,
    input  wire aux_test_pkg::nibble_t adc_i_sample,
    input  wire aux_test_pkg::nibble_t adc_q_sample,
    input  wire logic              production_test_signal,
    input  wire logic              transmit_active_flag,
    input  wire logic              receive_active_flag,
    input  wire logic              subcarrier_flag,
    input  wire logic              baud_is_106,
    input  wire logic [7:0]        test_bus,
    input  wire logic [2:0]        test_bus_bit_select
);
    import aux_test_pkg::*;

    always_comb begin
        pin.pin_out  = 1'b0;
        pin.pin_oe   = 1'b0;
        pin.level    = '0;
        pin.level_en = 1'b0;
        case (pin.sel)
            // RULE3: DAC value route
            SEL_DAC: begin
                pin.level    = pin.dac;
                pin.level_en = 1'b1;
            end
            // RULE4: correlator test signal
            SEL_CORR: begin
                pin.pin_out = correlator_signal;
                pin.pin_oe  = 1'b1;
            end
            // RULE4: DAC path sources
            SEL_MINLVL: begin
                pin.level    = {receiver_minimum_level, 2'b00};
                pin.level_en = 1'b1;
            end
            SEL_ADC_I: begin
                pin.level    = {adc_i_sample, 2'b00};
                pin.level_en = 1'b1;
            end
            SEL_ADC_Q: begin
                pin.level    = {adc_q_sample, 2'b00};
                pin.level_en = 1'b1;
            end
            // RULE5: production test code
            SEL_PROD: begin
                pin.pin_out = production_test_signal;
                pin.pin_oe  = 1'b1;
            end
            // RULE2: fixed levels
            SEL_HIGH: begin
                pin.pin_out = 1'b1;
                pin.pin_oe  = 1'b1;
            end
            SEL_LOW: begin
                pin.pin_out = 1'b0;
                pin.pin_oe  = 1'b1;
            end
            // RULE6: transmit active
            SEL_TX: begin
                pin.pin_out = transmit_active_flag;
                pin.pin_oe  = 1'b1;
            end
            // RULE7: receive active
            SEL_RX: begin
                pin.pin_out = receive_active_flag;
                pin.pin_oe  = 1'b1;
            end
            // RULE8: subcarrier, low at 106 kBd
            SEL_SUBC: begin
                pin.pin_out = subcarrier_flag & ~baud_is_106;
                pin.pin_oe  = 1'b1;
            end
            // RULE9 RULE15: test bus bit
            SEL_BUS_BIT: begin
                pin.pin_out = test_bus[test_bus_bit_select];
                pin.pin_oe  = 1'b1;
            end
            // RULE2 RULE5: high impedance and reserved
            default: begin
                pin.pin_oe = 1'b0;
            end
        endcase
    end
endmodule

// ---- bench/analog_test_aux_register_bank_tb.sv ----
// Self-checking bench for the aux test register bank
`timescale 1ns/1ps
`include "aux_test_params.svh"
module analog_test_aux_register_bank_tb;
    import aux_test_pkg::*;
    // Arbitrary version value
    localparam logic [7:0] VERSION = 8'h3C;
    logic        clk_sys;
    logic        arst_n;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        corr;
    logic        prod;
    logic        tx;
    logic        rx;
    logic        subc;
    logic        baud;
    nibble_t     minlvl;
    nibble_t     adc_i;
    nibble_t     adc_q;
    logic [7:0]  tbus;
    logic        o1;
    logic        e1;
    logic        le1;
    logic        o2;
    logic        e2;
    logic        le2;
    dac_val_t    l1;
    dac_val_t    l2;
    dac_val_t    dac_exp [2];
    logic [2:0]  bsel;
    logic [31:0] rd;
    logic        err;
    int          mismatches;
    int          checks_done;
    int          cycles;

    analog_test_aux_register_bank #(.VERSION_CODE(VERSION)) dut_u (
        .clk_sys(clk_sys), .arst_n(arst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .correlator_signal(corr), .receiver_minimum_level(minlvl),
        .adc_i_sample(adc_i), .adc_q_sample(adc_q),
        .production_test_signal(prod), .transmit_active_flag(tx),
        .receive_active_flag(rx), .subcarrier_flag(subc),
        .baud_is_106(baud), .test_bus(tbus),
        .first_auxiliary_pin_out(o1), .first_auxiliary_pin_oe(e1),
        .first_auxiliary_pin_level(l1), .first_auxiliary_pin_level_en(le1),
        .second_auxiliary_pin_out(o2), .second_auxiliary_pin_oe(e2),
        .second_auxiliary_pin_level(l2), .second_auxiliary_pin_level_en(le2)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
        @(posedge clk_sys);
        paddr   <= idx << 2;
        pwrite  <= wr;
        pwdata  <= {24'h00_0000, wd};
        psel    <= 1'b1;
        penable <= 1'b0;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string what, input logic [7:0] idx,
                         input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(what, rd, exp);
        check("slave error", {31'h0000_0000, err}, 32'h0000_0000);
    endtask

    // Expected pin state from the selector code
    task automatic check_pin(input int p, input aux_sel_t code);
        logic [1:0] kind;
        logic       ed;
        logic [5:0] el;
        kind = 2'd1;
        ed = 1'b0;
        el = 6'h00;
        case (code)
            SEL_HIZ, SEL_RSV3, SEL_RSV7, SEL_RSV9: kind = 2'd0;
            SEL_DAC: begin
                kind = 2'd2;
                el = dac_exp[p];
            end
            SEL_MINLVL: begin
                kind = 2'd2;
                el = {minlvl, 2'b00};
            end
            SEL_ADC_I: begin
                kind = 2'd2;
                el = {adc_i, 2'b00};
            end
            SEL_ADC_Q: begin
                kind = 2'd2;
                el = {adc_q, 2'b00};
            end
            SEL_CORR: ed = corr;
            SEL_PROD: ed = prod;
            SEL_HIGH: ed = 1'b1;
            SEL_LOW: ed = 1'b0;
            SEL_TX: ed = tx;
            SEL_RX: ed = rx;
            SEL_SUBC: ed = subc & ~baud;
            default: ed = tbus[bsel];
        endcase
        if (kind == 2'd0) begin
            check("pin oe", {31'h0000_0000, p ? e2 : e1}, 32'h0000_0000);
            check("pin level en", {31'h0000_0000, p ? le2 : le1}, 32'h0);
        end else if (kind == 2'd1) begin
            check("pin oe", {31'h0000_0000, p ? e2 : e1}, 32'h0000_0001);
            check("pin out", {31'h0000_0000, p ? o2 : o1}, {31'h0, ed});
        end else begin
            check("pin level en", {31'h0, p ? le2 : le1}, 32'h0000_0001);
            check("pin level", {26'h000_0000, p ? l2 : l1}, {26'h0, el});
        end
    endtask

    initial begin
        arst_n = 1'b0;
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
        {corr, prod, tx, rx, subc, baud} = 6'h00;
        {minlvl, adc_i, adc_q} = 12'h000;
        tbus = 8'h00;
        bsel = 3'h0;
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        #1;
        check_pin(0, SEL_HIZ);
        check_pin(1, SEL_HIZ);
        rdchk("selectors", `AUX_SEL_IDX, 32'h0000_0000);
        rdchk("first dac", `FIRST_DAC_IDX, 32'h0000_0000);
        rdchk("second dac", `SECOND_DAC_IDX, 32'h0000_0000);
        rdchk("bit select", `TEST_SEL_IDX, 32'h0000_0000);
        rdchk("version", `SILICON_VERSION_IDX, {24'h0, VERSION});
        apb(1'b1, `SILICON_VERSION_IDX, ~VERSION);
        rdchk("version", `SILICON_VERSION_IDX, {24'h0, VERSION});
        apb(1'b1, `PROD_TEST_IDX, 8'h00);
        rdchk("reserved", `PROD_TEST_IDX, 32'h0000_00FF);
        apb(1'b0, 8'h20, 8'h00);
        check("unmapped data", rd, 32'h0000_0000);
        check("unmapped error", {31'h0000_0000, err}, 32'h0000_0001);
        for (int p = 0; p < 2; p++) begin
            corr <= p[0];
            prod <= ~p[0];
            tx <= p[0];
            rx <= ~p[0];
            subc <= 1'b1;
            baud <= p[0];
            minlvl <= p ? 4'h3 : 4'h9;
            adc_i <= p ? 4'hA : 4'h6;
            adc_q <= p ? 4'h1 : 4'hC;
            tbus <= p ? 8'h5A : 8'hA5;
            bsel = p ? 3'h6 : 3'h1;
            dac_exp[0] = p ? 6'h2A : 6'h3F;
            dac_exp[1] = p ? 6'h15 : 6'h05;
            apb(1'b1, `TEST_SEL_IDX, {5'h00, bsel});
            apb(1'b1, `FIRST_DAC_IDX, p ? 8'h2A : 8'hFF);
            apb(1'b1, `SECOND_DAC_IDX, p ? 8'h15 : 8'hC5);
            apb(1'b1, `ADC_IQ_IDX, 8'h00);
            rdchk("first dac", `FIRST_DAC_IDX, {26'h0, dac_exp[0]});
            rdchk("second dac", `SECOND_DAC_IDX,
                  {26'h0, dac_exp[1]});
            rdchk("adc sample", `ADC_IQ_IDX, {24'h0, adc_i, adc_q});
            for (int c = 0; c < 16; c++) begin
                apb(1'b1, `AUX_SEL_IDX, {c[3:0], ~c[3:0]});
                repeat (`PIN_LATENCY) @(posedge clk_sys);
                #1;
                check_pin(0, aux_sel_t'(c[3:0]));
                check_pin(1, aux_sel_t'(~c[3:0]));
                rdchk("selectors", `AUX_SEL_IDX,
                      {24'h0, c[3:0], ~c[3:0]});
            end
        end
        @(posedge clk_sys);
        arst_n <= 1'b0;
        @(posedge clk_sys);
        #1;
        check_pin(0, SEL_HIZ);
        check_pin(1, SEL_HIZ);
        @(posedge clk_sys);
        arst_n <= 1'b1;
        rdchk("selectors", `AUX_SEL_IDX, 32'h0000_0000);
        report_and_stop();
    end
endmodule
